// ### hw/swr_regs.vh
/*
 * constants of the single-wire identification and command layer:
 * timing figures in microseconds, cycle conversion, command codes,
 * crc feedback and the linear address map.
 * assumes the includer runs on a 25 MHz core clock.
 */
`ifndef SWR_REGS_VH
`define SWR_REGS_VH

////////////////////////////////////////////////////////////////////////
// clock and bus timing
`define SWR_CLK_MHZ        25
`define SWR_T_RST_STD_US   480
`define SWR_T_RST_OD_US    48
`define SWR_T_SAMP_STD_US  30
`define SWR_T_SAMP_OD_US   3
`define SWR_T_PDH_STD_US   30
`define SWR_T_PDH_OD_US    3
`define SWR_T_PDL_STD_US   120
`define SWR_T_PDL_OD_US    12
`define SWR_US2CYC(t)      ((t) * `SWR_CLK_MHZ)

////////////////////////////////////////////////////////////////////////
// identification code function commands
`define SWR_CMD_READ       8'h33
`define SWR_CMD_MATCH      8'h55
`define SWR_CMD_SEARCH     8'hF0
`define SWR_CMD_CSEARCH    8'hEC
`define SWR_CMD_SKIP       8'hCC
`define SWR_CMD_OD_SKIP    8'h3C
`define SWR_CMD_OD_MATCH   8'h69
`define SWR_CMD_RESUME     8'hA5

////////////////////////////////////////////////////////////////////////
// crc: right shift, feedback mask for x^8 + x^5 + x^4 + 1
`define SWR_CRC_FB         8'h8C
`define SWR_CRC_RST        8'h00
`define SWR_CRC_DATA_BITS  6'd55
`define SWR_CRC_LAST_BIT   6'd63

////////////////////////////////////////////////////////////////////////
// linear address map (14-bit byte addresses)
`define SWR_A_GP_HI        14'h01FF
`define SWR_A_REG_LO       14'h0200
`define SWR_A_REG_HI       14'h023F
`define SWR_A_CAL_HI       14'h027F
`define SWR_A_LOG_LO       14'h1000
`define SWR_A_LOG_HI       14'h2FFF
`define SWR_A_RO1_LO       14'h020C
`define SWR_A_RO1_HI       14'h020F
`define SWR_A_RO2_LO       14'h0214
`define SWR_A_RO2_HI       14'h0215
`define SWR_A_CNT_LO       14'h0219
`define SWR_A_CNT_HI       14'h021F
`define SWR_A_PW_LO        14'h0227
`define SWR_A_PW_HI        14'h0236

`endif

// ### hw/swr_rom_layer.v
/*
 * single-wire identification and command layer of a logging device:
 * slot timing, reset and presence, identification code with crc,
 * function command handling, speed switch and memory access checks.
 * assumes the io pin is open drain with an external pull-up and that
 * the memory layer behind it follows the grant and mask outputs.
 */
`timescale 1ns/1ps
`include "swr_regs.vh"

module swr_rom_layer #(
  parameter [7:0]  FAMILY_CODE = 8'h5A,              // arbitrary value
  parameter [47:0] SERIAL_NUM  = 48'h0123_4567_89AB, // arbitrary value
  parameter [15:0] RST_STD_CYC = `SWR_US2CYC(`SWR_T_RST_STD_US)
) (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst_b,
  // single-wire pin
  input  wire        ioIn,
  output wire        ioOut,
  output wire        ioOe_b,
  // device conditions
  input  wire        alarmIn,
  input  wire        missionIn,
  // layer status
  output wire        memSel,
  output wire        odMode,
  output wire        romCrcOk,
  output wire [7:0]  romCrc,
  // memory command and data stream
  output wire [7:0]  memCmd,
  output wire        memCmdValid,
  output wire [7:0]  rxByte,
  output wire        rxValid,
  input  wire [7:0]  txByte,
  input  wire        txLoad,
  output wire        txReady,
  output wire        txDone,
  // access check
  input  wire [13:0] accAddr,
  input  wire        accWrite,
  output wire        accGrant,
  output wire        accMask,
  output wire        accScratch,
  output wire        accMapped
);

  localparam [15:0] RST_OD_CYC  = `SWR_US2CYC(`SWR_T_RST_OD_US);
  localparam [15:0] SAMP_STD    = `SWR_US2CYC(`SWR_T_SAMP_STD_US);
  localparam [15:0] SAMP_OD     = `SWR_US2CYC(`SWR_T_SAMP_OD_US);
  localparam [15:0] PDH_STD     = `SWR_US2CYC(`SWR_T_PDH_STD_US);
  localparam [15:0] PDH_OD      = `SWR_US2CYC(`SWR_T_PDH_OD_US);
  localparam [15:0] PDL_STD     = `SWR_US2CYC(`SWR_T_PDL_STD_US);
  localparam [15:0] PDL_OD      = `SWR_US2CYC(`SWR_T_PDL_OD_US);

  localparam [3:0] B_IDLE  = 4'b0001;
  localparam [3:0] B_LOW   = 4'b0010;
  localparam [3:0] B_PWAIT = 4'b0100;
  localparam [3:0] B_PDRV  = 4'b1000;

  localparam [6:0] T_IDLE  = 7'b000_0001;
  localparam [6:0] T_CMD   = 7'b000_0010;
  localparam [6:0] T_RDROM = 7'b000_0100;
  localparam [6:0] T_MATCH = 7'b000_1000;
  localparam [6:0] T_SRCH  = 7'b001_0000;
  localparam [6:0] T_MEM   = 7'b010_0000;
  localparam [6:0] T_DEAD  = 7'b100_0000;

  reg        ioS1_r, ioS2_r, ioPrev_r;
  reg [3:0]  bst_r;
  reg [15:0] cnt_r;
  reg        drvLow_r, slotDone_r, slotBit_r, rstEv_r, rstStdEv_r;
  reg [6:0]  tst_r;
  reg [5:0]  idx_r;
  reg [1:0]  phase_r;
  reg [7:0]  sh_r;
  reg [2:0]  bc_r;
  reg        od_r, resume_r, firstDone_r;
  reg [7:0]  memCmd_r, rxByte_r, txSh_r;
  reg        memCmdValid_r, rxValid_r, txBusy_r, txDone_r;
  reg [2:0]  txBc_r;
  reg [7:0]  crc_r, crcVal_r;
  reg [5:0]  crcIdx_r;
  reg        romReady_r, crcOk_r;
  reg        accGrant_r, accMask_r, accScratch_r, accMapped_r;

  wire [55:0] idBits  = {SERIAL_NUM, FAMILY_CODE};
  wire [63:0] romCode = {crcVal_r, idBits};
  wire        romBit  = romCode[idx_r];
  wire        fall    = ioPrev_r & ~ioS2_r;
  wire [15:0] sampCyc = od_r ? SAMP_OD : SAMP_STD;
  wire [15:0] rstCyc  = od_r ? RST_OD_CYC : RST_STD_CYC;
  wire [7:0]  rxNxt   = {slotBit_r, sh_r[7:1]};
  wire        inMem   = (tst_r == T_MEM);
  reg         txActive, txBit;

  ////////////////////////////////////////////////////////////////////////
  // pin synchroniser; the second stage and its delayed copy ioPrev_r feed logic, the first stage does not
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ioS1_r   <= 1'b1;
      ioS2_r   <= 1'b1;
      ioPrev_r <= 1'b1;
    end else begin
      ioS1_r   <= ioIn;
      ioS2_r   <= ioS1_r;
      ioPrev_r <= ioS2_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // crc engine: 56 id bits, then the 8 latched crc bits as a self check
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      crc_r      <= `SWR_CRC_RST;
      crcVal_r   <= `SWR_CRC_RST;
      crcIdx_r   <= 6'd0;
      romReady_r <= 1'b0;
      crcOk_r    <= 1'b0;
    end else if (!romReady_r) begin : crcStep
      reg       inBit;
      reg [7:0] nxt;
      inBit = (crcIdx_r <= `SWR_CRC_DATA_BITS) ? idBits[crcIdx_r] : crcVal_r[crcIdx_r[2:0]];
      nxt   = (crc_r >> 1) ^ ((crc_r[0] ^ inBit) ? `SWR_CRC_FB : 8'h00);
      crc_r <= nxt;
      crcIdx_r <= crcIdx_r + 6'd1;
      if (crcIdx_r == `SWR_CRC_DATA_BITS)
        crcVal_r <= nxt;
      if (crcIdx_r == `SWR_CRC_LAST_BIT) begin
        romReady_r <= 1'b1;
        crcOk_r    <= (nxt == 8'h00);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // what the next slot sends when the device talks
  always @* begin
    txActive = 1'b0;
    txBit    = 1'b1;
    case (tst_r)
      T_RDROM: begin
        txActive = 1'b1;
        txBit    = romBit;
      end
      T_SRCH: begin
        txActive = (phase_r != 2'd2);
        txBit    = (phase_r == 2'd0) ? romBit : ~romBit;
      end
      T_MEM: begin
        txActive = txBusy_r;
        txBit    = txSh_r[0];
      end
      default: begin
        txActive = 1'b0;
        txBit    = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // slot timing, reset detection and presence pulse
  // a reset pulse also yields one junk slot at the sample point; the
  // reset event that follows throws it away
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bst_r      <= B_IDLE;
      cnt_r      <= 16'h0000;
      drvLow_r   <= 1'b0;
      slotDone_r <= 1'b0;
      slotBit_r  <= 1'b1;
      rstEv_r    <= 1'b0;
      rstStdEv_r <= 1'b0;
    end else begin
      slotDone_r <= 1'b0;
      rstEv_r    <= 1'b0;
      rstStdEv_r <= 1'b0;
      case (bst_r)
        B_IDLE: begin
          if (fall && romReady_r) begin
            cnt_r    <= 16'h0000;
            drvLow_r <= txActive & ~txBit;
            bst_r    <= B_LOW;
          end
        end
        B_LOW: begin
          if (cnt_r != 16'hFFFF)
            cnt_r <= cnt_r + 16'h0001;
          if (cnt_r == sampCyc - 16'h0001) begin
            drvLow_r   <= 1'b0;
            slotDone_r <= 1'b1;
            slotBit_r  <= ioS2_r;
          end
          if (ioS2_r && cnt_r >= sampCyc) begin
            if (cnt_r >= rstCyc) begin
              rstEv_r    <= 1'b1;
              rstStdEv_r <= (cnt_r >= RST_STD_CYC);
              cnt_r      <= 16'h0000;
              bst_r      <= B_PWAIT;
            end else begin
              bst_r <= B_IDLE;
            end
          end
        end
        B_PWAIT: begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r >= (od_r ? PDH_OD : PDH_STD)) begin
            cnt_r    <= 16'h0000;
            drvLow_r <= 1'b1;
            bst_r    <= B_PDRV;
          end
        end
        B_PDRV: begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r >= (od_r ? PDL_OD : PDL_STD) - 16'h0001) begin
            drvLow_r <= 1'b0;
            bst_r    <= B_IDLE;
          end
        end
        default: begin
          drvLow_r <= 1'b0;
          bst_r    <= B_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transaction layer: code command first, then memory traffic
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tst_r <= T_IDLE;
      idx_r <= 6'd0;
      phase_r <= 2'd0;
      sh_r <= 8'h00;
      bc_r <= 3'd0;
      od_r <= 1'b0;
      resume_r <= 1'b0;
      firstDone_r <= 1'b0;
      memCmd_r <= 8'h00;
      rxByte_r <= 8'h00;
      memCmdValid_r <= 1'b0;
      rxValid_r <= 1'b0;
      txSh_r <= 8'h00;
      txBusy_r <= 1'b0;
      txBc_r <= 3'd0;
      txDone_r <= 1'b0;
    end else begin
      memCmdValid_r <= 1'b0;
      rxValid_r     <= 1'b0;
      txDone_r      <= 1'b0;
      if (rstEv_r) begin
        tst_r       <= T_CMD;
        bc_r        <= 3'd0;
        txBusy_r    <= 1'b0;
        firstDone_r <= 1'b0;
        if (rstStdEv_r)
          od_r <= 1'b0;
      end else if (slotDone_r) begin
        case (tst_r)
          T_CMD: begin
            sh_r    <= rxNxt;
            bc_r    <= bc_r + 3'd1;
            idx_r   <= 6'd0;
            phase_r <= 2'd0;
            if (bc_r == 3'd7) begin
              case (rxNxt)
                `SWR_CMD_READ: begin
                  tst_r <= T_RDROM;
                  resume_r <= 1'b0;
                end
                `SWR_CMD_MATCH: tst_r <= T_MATCH;
                `SWR_CMD_OD_MATCH: begin
                  tst_r <= T_MATCH;
                  od_r  <= 1'b1;
                end
                `SWR_CMD_SEARCH: tst_r <= T_SRCH;
                `SWR_CMD_CSEARCH: tst_r <= alarmIn ? T_SRCH : T_DEAD;
                `SWR_CMD_SKIP: begin
                  tst_r <= T_MEM;
                  resume_r <= 1'b0;
                end
                `SWR_CMD_OD_SKIP: begin
                  tst_r <= T_MEM;
                  resume_r <= 1'b0;
                  od_r <= 1'b1;
                end
                `SWR_CMD_RESUME: tst_r <= resume_r ? T_MEM : T_DEAD;
                default: tst_r <= T_DEAD;
              endcase
            end
          end
          T_RDROM: begin
            idx_r <= idx_r + 6'd1;
            if (idx_r == 6'd63)
              tst_r <= T_MEM;
          end
          T_MATCH: begin
            idx_r <= idx_r + 6'd1;
            if (slotBit_r != romBit) begin
              tst_r <= T_DEAD;
              resume_r <= 1'b0;
            end else if (idx_r == 6'd63) begin
              tst_r <= T_MEM;
              resume_r <= 1'b1;
            end
          end
          T_SRCH: begin
            phase_r <= (phase_r == 2'd2) ? 2'd0 : phase_r + 2'd1;
            if (phase_r == 2'd2) begin
              idx_r <= idx_r + 6'd1;
              if (slotBit_r != romBit) begin
                tst_r <= T_DEAD;
                resume_r <= 1'b0;
              end else if (idx_r == 6'd63) begin
                tst_r <= T_MEM;
                resume_r <= 1'b1;
              end
            end
          end
          T_MEM: begin
            if (txBusy_r) begin
              txSh_r <= {1'b1, txSh_r[7:1]};
              txBc_r <= txBc_r + 3'd1;
              if (txBc_r == 3'd7) begin
                txBusy_r <= 1'b0;
                txDone_r <= 1'b1;
              end
            end else begin
              sh_r <= rxNxt;
              bc_r <= bc_r + 3'd1;
              if (bc_r == 3'd7) begin
                firstDone_r <= 1'b1;
                if (!firstDone_r) begin
                  memCmd_r <= rxNxt;
                  memCmdValid_r <= 1'b1;
                end else begin
                  rxByte_r  <= rxNxt;
                  rxValid_r <= 1'b1;
                end
              end
            end
          end
          default: tst_r <= tst_r;
        endcase
      end
      if (!rstEv_r && inMem && !txBusy_r && txLoad && !(slotDone_r && bc_r == 3'd7)) begin
        txSh_r   <= txByte;
        txBusy_r <= 1'b1;
        txBc_r   <= 3'd0;
      end
      if (!romReady_r)
        tst_r <= T_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // access check for the memory layer, one cycle behind the address
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      accGrant_r   <= 1'b0;
      accMask_r    <= 1'b0;
      accScratch_r <= 1'b0;
      accMapped_r  <= 1'b0;
    end else begin : accChk
      reg inGp, inReg, inCal, inLog, ro, pw, ok;
      inGp  = (accAddr <= `SWR_A_GP_HI);
      inReg = (accAddr >= `SWR_A_REG_LO) && (accAddr <= `SWR_A_REG_HI);
      inCal = (accAddr > `SWR_A_REG_HI) && (accAddr <= `SWR_A_CAL_HI);
      inLog = (accAddr >= `SWR_A_LOG_LO) && (accAddr <= `SWR_A_LOG_HI);
      ro    = inLog
            | ((accAddr >= `SWR_A_RO1_LO) && (accAddr <= `SWR_A_RO1_HI))
            | ((accAddr >= `SWR_A_RO2_LO) && (accAddr <= `SWR_A_RO2_HI))
            | ((accAddr >= `SWR_A_CNT_LO) && (accAddr <= `SWR_A_CNT_HI));
      pw    = (accAddr >= `SWR_A_PW_LO) && (accAddr <= `SWR_A_PW_HI);
      ok    = (inGp | inReg | inCal | inLog) & inMem;
      if (accWrite)
        ok = ok & ~ro & ~(inReg & missionIn);
      accGrant_r   <= ok;
      accMapped_r  <= inGp | inReg | inCal | inLog;
      accMask_r    <= ~accWrite & pw;
      accScratch_r <= accWrite & ok & (inGp | inReg);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs; the pin only ever pulls low
  assign ioOut       = 1'b0;
  assign ioOe_b      = ~drvLow_r;
  assign memSel      = inMem;
  assign odMode      = od_r;
  assign romCrcOk    = crcOk_r;
  assign romCrc      = crcVal_r;
  assign memCmd      = memCmd_r;
  assign memCmdValid = memCmdValid_r;
  assign rxByte      = rxByte_r;
  assign rxValid     = rxValid_r;
  assign txReady     = inMem & ~txBusy_r;
  assign txDone      = txDone_r;
  assign accGrant    = accGrant_r;
  assign accMask     = accMask_r;
  assign accScratch  = accScratch_r;
  assign accMapped   = accMapped_r;

endmodule

// ### dv/swr_rom_layer_asserts.sv
/* checker for the single-wire layer: access answers, selection, speed and crc.
   assumes it is bound to swr_rom_layer and sees only that module's ports. */
`timescale 1ns/1ps
module swr_rom_layer_asserts #(
  parameter [15:0] RST_STD_CYC = 16'h2EE0
) (
  // clock and reset
  input wire        core_clk,
  input wire        rst_b,
  // wire level
  input wire        ioIn,
  // layer status
  input wire        memSel,
  input wire        odMode,
  input wire        romCrcOk,
  input wire        memCmdValid,
  input wire        rxValid,
  input wire        txDone,
  // access query and answer
  input wire [13:0] accAddr,
  input wire        accWrite,
  input wire        missionIn,
  input wire        accGrant,
  input wire        accMask,
  input wire        accScratch,
  input wire        accMapped
);
  reg [15:0] lowCnt_r;
  reg [15:0] lastLow_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////////////
  // length of the last low pulse; saturates so a stuck line cannot wrap
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lowCnt_r <= 16'h0000;
      lastLow_r <= 16'h0000;
    end else if (!ioIn) begin
      lowCnt_r <= (lowCnt_r == 16'hFFFF) ? lowCnt_r : lowCnt_r + 16'h0001;
    end else begin
      if (lowCnt_r != 16'h0000) lastLow_r <= lowCnt_r;
      lowCnt_r <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // access answers come one cycle after the query
  chk_grant_map: assert property (accGrant |-> accMapped) else $error("grant outside mapped space");
  chk_grant_sel: assert property (accGrant |-> $past(memSel)) else $error("grant while not selected");
  chk_log_ro: assert property ($past(accWrite && accAddr >= 14'h1000) |-> !accGrant)
    else $error("write granted to log memory");
  chk_mission_lock: assert property ($past(accWrite && missionIn && accAddr[13:6] == 8'h08) |-> !accGrant)
    else $error("register page write granted in mission");
  chk_pw_mask: assert property (accGrant && $past(!accWrite) |->
    accMask == $past(accAddr >= 14'h0227 && accAddr <= 14'h0236)) else $error("password read not masked");
  chk_scratch_way: assert property (accScratch |-> accGrant && $past(accWrite && accAddr <= 14'h023F))
    else $error("scratch flag on wrong access");
  // traffic to the memory layer only while selected
  chk_cmd_sel: assert property (memCmdValid |-> memSel) else $error("memory command while deselected");
  chk_data_sel: assert property (rxValid || txDone |-> memSel) else $error("data byte while deselected");
  // the speed drops only after a standard-length reset pulse
  chk_od_leave: assert property ($fell(odMode) |-> lastLow_r + 16'h0002 >= RST_STD_CYC)
    else $error("overdrive left without long reset");
  chk_crc_hold: assert property (romCrcOk |=> romCrcOk) else $error("crc self check dropped");

  cover property (memCmdValid);
  cover property (txDone);
  cover property ($rose(odMode));
  cover property ($fell(odMode));
  cover property (accMask);
endmodule

bind swr_rom_layer swr_rom_layer_asserts #(.RST_STD_CYC(RST_STD_CYC)) swr_rom_layer_asserts_i (
  .core_clk(core_clk), .rst_b(rst_b), .ioIn(ioIn), .memSel(memSel), .odMode(odMode),
  .romCrcOk(romCrcOk), .memCmdValid(memCmdValid), .rxValid(rxValid), .txDone(txDone),
  .accAddr(accAddr), .accWrite(accWrite), .missionIn(missionIn), .accGrant(accGrant),
  .accMask(accMask), .accScratch(accScratch), .accMapped(accMapped));

// ### dv/swr_master_model.sv
/* behavioural bus master for the single-wire link: reset pulses, write and
   read slots at standard or overdrive speed. assumes an open-drain wire with a
   pull-up, with its level computed outside and fed back on lineIn. */
`timescale 1ns/1ps
module swr_master_model (
  // clock
  input  wire core_clk,
  // wire level and master pull-down enable, low = pulling
  input  wire lineIn,
  output reg  mOe_b
);
  reg od;

  initial begin
    mOe_b = 1'b1;
    od = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // all line changes land on falling edges, away from the device's sampling
  task automatic hold(input integer n);
    repeat (n) @(negedge core_clk);
  endtask

  // reset pulse, then presence sampled inside the device's low window
  task automatic busReset(input integer lowCyc, output reg seen);
    mOe_b = 1'b0;
    hold(lowCyc);
    mOe_b = 1'b1;
    hold(od ? 150 : 1500);
    seen = !lineIn;
    hold(od ? 400 : 2400);
  endtask

  task automatic writeBit(input b);
    mOe_b = 1'b0;
    hold(b ? (od ? 10 : 50) : (od ? 100 : 800));
    mOe_b = 1'b1;
    hold(b ? (od ? 190 : 850) : 100);
  endtask

  // short pull, then sample well before the device lets go
  task automatic readBit(output reg b);
    mOe_b = 1'b0;
    hold(od ? 5 : 25);
    mOe_b = 1'b1;
    hold(od ? 35 : 375);
    b = lineIn;
    hold(od ? 160 : 500);
  endtask

  task automatic writeBits(input integer n, input [63:0] v);
    integer i;
    for (i = 0; i < n; i++) writeBit(v[i]);
  endtask

  task automatic readBits(input integer n, output reg [63:0] v);
    integer i;
    reg b;
    v = 64'h0;
    for (i = 0; i < n; i++) begin
      readBit(b);
      v[i] = b;
    end
  endtask
endmodule

// ### dv/swr_rom_layer_tb.sv
/* self-checking bench for the single-wire layer; the master model drives
   the wire. assumes the layer's timing in core clock cycles at 25 MHz. */
`timescale 1ns/1ps
module swr_rom_layer_tb;
  localparam [7:0]  FAM  = 8'h5A;               // arbitrary value
  localparam [47:0] SER  = 48'h0123_4567_89AB;  // arbitrary value
  localparam [15:0] RSTC = 16'h07D0;            // shortened standard reset
  reg         core_clk, rst_b, alarmIn, missionIn, txLoad, accWrite, pres;
  reg  [7:0]  txByte, cmdSeen, rxSeen;
  reg  [13:0] accAddr;
  reg  [63:0] v, code;
  integer     cmdCnt, doneCnt, badCount, samplesChecked;
  wire        ioOut, ioOe_b, mOe_b, memSel, odMode, romCrcOk, memCmdValid;
  wire        rxValid, txReady, txDone, accGrant, accMask, accScratch, accMapped;
  wire [7:0]  romCrc, memCmd, rxByte;
  wire        lineLvl = ioOe_b & mOe_b;  // pull-up wins unless someone pulls

  swr_rom_layer #(.FAMILY_CODE(FAM), .SERIAL_NUM(SER), .RST_STD_CYC(RSTC)) swr_rom_layer_i (
    .core_clk(core_clk), .rst_b(rst_b), .ioIn(lineLvl), .ioOut(ioOut), .ioOe_b(ioOe_b),
    .alarmIn(alarmIn), .missionIn(missionIn), .memSel(memSel), .odMode(odMode),
    .romCrcOk(romCrcOk), .romCrc(romCrc), .memCmd(memCmd), .memCmdValid(memCmdValid),
    .rxByte(rxByte), .rxValid(rxValid), .txByte(txByte), .txLoad(txLoad), .txReady(txReady),
    .txDone(txDone), .accAddr(accAddr), .accWrite(accWrite), .accGrant(accGrant),
    .accMask(accMask), .accScratch(accScratch), .accMapped(accMapped));
  swr_master_model swr_master_model_i (.core_clk(core_clk), .lineIn(lineLvl), .mOe_b(mOe_b));
  ////////////////////////////////////////////////////////////////////////
  // one-cycle pulses are caught here so no scenario can miss them
  always @(posedge core_clk) begin
    if (memCmdValid) begin
      cmdSeen <= memCmd;
      cmdCnt <= cmdCnt + 1;
    end
    if (rxValid) rxSeen <= rxByte;
    if (txDone) doneCnt <= doneCnt + 1;
  end
  task automatic cmp(input string what, input [63:0] exp, input [63:0] got);
    samplesChecked++;
    if (got !== exp) begin
      badCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // own reflected crc, feedback 8C for x^8+x^5+x^4+1
  function automatic [7:0] crc8(input [63:0] d, input integer n);
    reg [7:0] c;
    integer   i;
    c = 8'h00;
    for (i = 0; i < n; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8C : 8'h00);
    return c;
  endfunction
  task automatic accCheck(input [13:0] a, input w, input m, input [3:0] e);
    accAddr = a;
    accWrite = w;
    missionIn = m;
    @(negedge core_clk);
    cmp("grant mask scratch mapped", {60'h0, e}, {60'h0, accGrant, accMask, accScratch, accMapped});
  endtask
  task automatic busReset(input integer n);
    swr_master_model_i.busReset(n, pres);
    cmp("presence", 1, pres);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_crc;
    repeat (80) @(negedge core_clk);
    cmp("romCrc", code[63:56], romCrc);
    cmp("romCrcOk", 1, romCrcOk);
    cmp("ioOut", 0, ioOut);
    $display("test crc done");
  endtask
  task automatic t_odSkip;
    busReset(RSTC + 100);
    swr_master_model_i.writeBits(8, 64'h3C);
    cmp("odMode", 1, odMode);
    cmp("memSel", 1, memSel);
    swr_master_model_i.od = 1'b1;
    $display("test overdrive skip done");
  endtask
  task automatic t_readCode;
    busReset(1300);
    cmp("odMode kept", 1, odMode);
    swr_master_model_i.writeBits(8, 64'h33);
    swr_master_model_i.readBits(64, v);
    cmp("code", code, v);
    cmp("crc residue", 0, crc8(v, 64));
    $display("test read code done");
  endtask
  task automatic t_memTraffic;
    swr_master_model_i.writeBits(8, 64'hA6);
    cmp("memCmd", {cmdCnt, cmdSeen}, {32'd1, 8'hA6});
    cmp("txReady", 1, txReady);
    txByte = 8'h5C;
    txLoad = 1'b1;
    @(negedge core_clk);
    txLoad = 1'b0;
    swr_master_model_i.readBits(8, v);
    cmp("tx byte", {doneCnt, 8'h5C}, {32'd1, v[7:0]});
    swr_master_model_i.writeBits(8, 64'h3B);
    cmp("rxByte", 8'h3B, rxSeen);
    accCheck(14'h0010, 1, 0, 4'b1011);
    accCheck(14'h0200, 1, 0, 4'b1011);
    accCheck(14'h0200, 1, 1, 4'b0001);
    accCheck(14'h0230, 1, 1, 4'b0001);
    accCheck(14'h1000, 1, 0, 4'b0001);
    accCheck(14'h2FFF, 0, 0, 4'b1001);
    accCheck(14'h020C, 1, 0, 4'b0001);
    accCheck(14'h0227, 0, 0, 4'b1101);
    accCheck(14'h0236, 1, 0, 4'b1011);
    accCheck(14'h0240, 1, 0, 4'b1001);
    accCheck(14'h0280, 0, 0, 4'b0000);
    $display("test memory traffic done");
  endtask
  task automatic t_match(input [63:0] c, input sel, input [7:0] cmd);
    busReset(1300);
    swr_master_model_i.writeBits(8, {56'h0, cmd});
    swr_master_model_i.writeBits(64, c);
    cmp("memSel after match", sel, memSel);
    $display("test match done");
  endtask
  // resume after a good match, then conditional search with no alarm goes deaf
  task automatic t_resumeCond;
    busReset(1300);
    swr_master_model_i.writeBits(8, 64'hA5);
    cmp("memSel resume", 1, memSel);
    busReset(1300);
    alarmIn = 1'b0;
    swr_master_model_i.writeBits(8, 64'hEC);
    cmp("memSel cond search", 0, memSel);
    $display("test resume and conditional search done");
  endtask
  // first code bits of a search: bit, then its inverse, then the chosen bit
  task automatic t_search;
    integer   k;
    reg [63:0] r;
    busReset(1300);
    swr_master_model_i.writeBits(8, 64'hF0);
    for (k = 0; k < 4; k++) begin
      swr_master_model_i.readBits(2, r);
      cmp("search bit pair", {~code[k], code[k]}, r[1:0]);
      swr_master_model_i.writeBit(code[k]);
    end
    cmp("memSel mid search", 0, memSel);
    $display("test search done");
  endtask
  task automatic t_refuse;
    busReset(1300);
    swr_master_model_i.writeBits(8, 64'h12);
    swr_master_model_i.writeBits(8, 64'hA6);
    cmp("deaf", {cmdCnt, 1'b0}, {32'd1, memSel});
    accCheck(14'h0010, 0, 0, 4'b0001);
    $display("test refuse done");
  endtask
  task automatic t_stdBack;
    swr_master_model_i.od = 1'b0;
    busReset(RSTC + 100);
    cmp("odMode cleared", 0, odMode);
    swr_master_model_i.writeBits(8, 64'hCC);
    cmp("memSel std", 1, memSel);
    $display("test standard return done");
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    repeat (100000) @(posedge core_clk);
    badCount++;
    $display("CHECK FAILED run length expected end seen hang");
    conclude;
  end
  initial begin
    {rst_b, alarmIn, missionIn, txLoad, accWrite} = 5'b00000;
    {txByte, accAddr, cmdCnt, doneCnt, badCount, samplesChecked} = 0;
    code = {crc8({8'h00, SER, FAM}, 56), SER, FAM};
    repeat (3) @(negedge core_clk);
    rst_b = 1'b1;
    t_crc;
    t_odSkip;
    t_readCode;
    t_memTraffic;
    t_match(code, 1, 8'h55);
    t_resumeCond;
    t_match(code ^ 64'h0010_0000, 0, 8'h69);
    t_search;
    t_refuse;
    t_stdBack;
    conclude;
  end
endmodule
